// *** hdl/dma_pkg.sv ***
package dma_pkg;
    localparam int NumChannels = 4;
    localparam int AddrWidth = 24;
    localparam int RegAddrWidth = 8;
    // Register map: global registers, then one eight-word window per channel.
    localparam logic [7:0] CtrlOffset = 8'h00;
    localparam logic [7:0] StatusOffset = 8'h01;
    localparam logic [7:0] IdOffset = 8'h02;
    localparam logic [7:0] ChanBase = 8'h10;
    localparam logic [7:0] ChanStride = 8'h08;
    localparam logic [2:0] ChCtrlIdx = 3'h0;
    localparam logic [2:0] ChSrcIdx = 3'h1;
    localparam logic [2:0] ChDstIdx = 3'h2;
    localparam logic [2:0] ChLenIdx = 3'h3;
    localparam logic [2:0] ChRepIdx = 3'h4;
    localparam logic [2:0] ChTrigIdx = 3'h5;
    localparam logic [2:0] ChStatIdx = 3'h6;
    // Channel control fields.
    localparam int EnableBit = 0;
    localparam int SwTrigBit = 1;
    localparam int ReloadBit = 2;
    localparam int LinkBit = 3;
    localparam int SrcModeLsb = 4;
    localparam int DstModeLsb = 6;
    localparam int BurstLsb = 8;
    // Global control fields.
    localparam int RoundRobinBit = 0;
    localparam int CpuFirstBit = 1;
    // Channel status fields.
    localparam int DoneBit = 0;
    localparam int ErrBit = 1;
    localparam int BusyBit = 2;
    localparam logic [31:0] CtrlReset = 32'h0000_0000;
    localparam logic [7:0] DeviceIdValue = 8'h5A; // Arbitrary value.
    // Data space regions.
    localparam logic [23:0] NvmBase = 24'h00_1000;
    localparam logic [23:0] NvmLimit = 24'h00_1FFF;
    localparam logic [23:0] ProgBase = 24'h80_0000;
    typedef enum logic [1:0] {
        AddrFixed = 2'b00,
        AddrInc = 2'b01,
        AddrDec = 2'b10
    } addr_mode_type;
    typedef enum logic [2:0] {
        StIdle = 3'b000,
        StRead = 3'b001,
        StWrite = 3'b010,
        StNext = 3'b011
    } dma_state_type;
endpackage : dma_pkg

// *** hdl/dma_arbiter.sv ***
module dma_arbiter #(
    parameter int N = 4
) (
    input wire logic clk,
    input wire logic rstSync_n,
    input wire logic [N-1:0] request,
    input wire logic roundRobin,
    input wire logic advance,
    output logic [1:0] grantIdx,
    output logic grantValid
);
    logic [1:0] lastGrant_ff;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            lastGrant_ff <= 2'h3;
        end else if (advance) begin
            lastGrant_ff <= grantIdx;
        end
    end

    // Fixed mode favours channel 0; rotating mode starts after the last win.
    always_comb begin
        logic [1:0] idx;
        idx = 2'h0;
        grantIdx = 2'h0;
        grantValid = 1'b0;
        for (int k = N - 1; k >= 0; k--) begin
            idx = roundRobin ? 2'(lastGrant_ff + 2'(k) + 2'h1) : 2'(k);
            if (request[idx]) begin
                grantIdx = idx;
                grantValid = 1'b1;
            end
        end
    end
endmodule : dma_arbiter

// *** hdl/dma_addr_step.sv ***
module dma_addr_step #(
    parameter int W = 24
) (
    input wire logic [W-1:0] addr,
    input wire logic [1:0] mode,
    output logic [W-1:0] nxtAddr
);
    always_comb begin
        case (mode)
            dma_pkg::AddrInc: nxtAddr = W'(addr + 1'b1);
            dma_pkg::AddrDec: nxtAddr = W'(addr - 1'b1);
            default: nxtAddr = addr;
        endcase
    end
endmodule : dma_addr_step

// *** hdl/direct_memory_mover.sv ***
// What this block does
// - Four channels each hold their own separate configuration registers.
// - A block is one byte up to 64 KiB long, set by the length register.
// - A repeat counter reissues the block so a transaction reaches 255 blocks, just under 16 MiB.
// - Source and destination each step up, down or stay, independently.
// - With reload set, finishing restores the starting addresses.
// - A grant moves a burst of one, two, four or eight bytes.
// - Software chooses fixed or rotating priority between channels.
// - A linked channel starts its partner when it finishes, and back.
// - Transfers use the shared data bus through a request and grant.
// - Peripheral registers are reached as plain data space addresses.
// - Any pairing of memory and peripheral addresses may be moved.
// - Reads from the mapped nonvolatile data region are allowed.
// - Writes to that region and any program space access are refused.
// - A channel starts on a peripheral request, an event or software.
// - Each channel has its own trigger inputs selected per channel.
// - The processor keeps or yields the bus by a fixed global choice.
module direct_memory_mover #(
    parameter int NumCh = dma_pkg::NumChannels,
    parameter int AW = dma_pkg::AddrWidth
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic [NumCh*4-1:0] periphReq,
    input wire logic [NumCh*4-1:0] eventReq,
    input wire logic cpuBusReq,
    output logic busReq,
    input wire logic busGrant,
    output logic [AW-1:0] busAddr,
    output logic [7:0] busWdata,
    output logic busWrite,
    output logic busRead,
    input wire logic [7:0] busRdata
);
    logic rstMeta_ff;
    logic rstSync_n;
    logic [31:0] glbCtrl_ff;
    logic [15:0] chCtrl_ff [NumCh];
    logic [AW-1:0] srcStart_ff [NumCh];
    logic [AW-1:0] dstStart_ff [NumCh];
    logic [AW-1:0] srcAddr_ff [NumCh];
    logic [AW-1:0] dstAddr_ff [NumCh];
    logic [15:0] blkLen_ff [NumCh];
    logic [16:0] blkCnt_ff [NumCh];
    logic [7:0] repeat_ff [NumCh];
    logic [7:0] repCnt_ff [NumCh];
    logic [7:0] trigSel_ff [NumCh];
    logic [NumCh-1:0] pending_ff;
    logic [NumCh-1:0] done_ff;
    logic [NumCh-1:0] err_ff;
    logic [NumCh*8-1:0] trigSync1_ff;
    logic [NumCh*8-1:0] trigSync2_ff;
    logic [NumCh-1:0] trigPrev_ff;
    logic [NumCh-1:0] trigRaw;
    logic [NumCh-1:0] chanReq;
    dma_pkg::dma_state_type state_ff;
    logic [1:0] curCh_ff;
    logic [3:0] burstCnt_ff;
    logic [7:0] dataHold_ff;
    logic [1:0] grantIdx;
    logic grantValid;
    logic [AW-1:0] nxtSrc;
    logic [AW-1:0] nxtDst;
    logic chanFinish;
    logic blockEnd;
    logic illegal;
    logic [1:0] rdCh;

    function automatic logic [3:0] burstBytes(input logic [1:0] code);
        burstBytes = 4'(1 << code);
    endfunction : burstBytes

    function automatic logic inNvm(input logic [AW-1:0] a);
        inNvm = (a >= dma_pkg::NvmBase) && (a <= dma_pkg::NvmLimit);
    endfunction : inNvm

    function automatic logic refused(input logic [AW-1:0] s,
        input logic [AW-1:0] d);
        refused = (s >= dma_pkg::ProgBase) || (d >= dma_pkg::ProgBase) ||
            inNvm(d);
    endfunction : refused

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_ff <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSync_n <= rstMeta_ff;
        end
    end

    // Each channel picks one of four peripheral lines or one of four events.
    // Lines are synchronised before the select; a select change onto a high line reads as an edge.
    for (genvar c = 0; c < NumCh; c++) begin : g_trig
        always_comb begin
            if (trigSel_ff[c][2]) begin
                trigRaw[c] = trigSync2_ff[NumCh*4 + c*4 +
                    32'(trigSel_ff[c][1:0])];
            end else begin
                trigRaw[c] = trigSync2_ff[c*4 +
                    32'(trigSel_ff[c][1:0])];
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            trigSync1_ff <= '0;
            trigSync2_ff <= '0;
            trigPrev_ff <= '0;
        end else begin
            trigSync1_ff <= {eventReq, periphReq};
            trigSync2_ff <= trigSync1_ff;
            trigPrev_ff <= trigRaw;
        end
    end

    dma_arbiter #(
        .N(NumCh)
    ) u_arb (
        .clk(clk),
        .rstSync_n(rstSync_n),
        .request(chanReq),
        .roundRobin(glbCtrl_ff[dma_pkg::RoundRobinBit]),
        .advance(state_ff == dma_pkg::StIdle && grantValid && busGrant &&
            busReq),
        .grantIdx(grantIdx),
        .grantValid(grantValid)
    );

    dma_addr_step #(.W(AW)) u_src (
        .addr(srcAddr_ff[curCh_ff]),
        .mode(chCtrl_ff[curCh_ff][dma_pkg::SrcModeLsb +: 2]),
        .nxtAddr(nxtSrc)
    );

    dma_addr_step #(.W(AW)) u_dst (
        .addr(dstAddr_ff[curCh_ff]),
        .mode(chCtrl_ff[curCh_ff][dma_pkg::DstModeLsb +: 2]),
        .nxtAddr(nxtDst)
    );

    always_comb begin
        for (int c = 0; c < NumCh; c++) begin
            chanReq[c] = pending_ff[c] && chCtrl_ff[c][dma_pkg::EnableBit];
        end
    end

    // The processor holding the bus with priority set stalls the engine.
    assign busReq = (|chanReq) && !(cpuBusReq &&
        glbCtrl_ff[dma_pkg::CpuFirstBit]);
    assign blockEnd = (blkCnt_ff[curCh_ff] == 17'h1);
    assign chanFinish = blockEnd && (repCnt_ff[curCh_ff] <= 8'h1);
    // Program space is never touched; nonvolatile data is read only.
    assign illegal = refused(srcAddr_ff[curCh_ff],
        dstAddr_ff[curCh_ff]);
    // Channel windows start above the global registers.
    assign rdCh = 2'((regAddr - dma_pkg::ChanBase) >> 3);

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_ff <= dma_pkg::StIdle;
            curCh_ff <= 2'h0;
            burstCnt_ff <= 4'h0;
            dataHold_ff <= 8'h00;
        end else begin
            case (state_ff)
                dma_pkg::StIdle: begin
                    if (grantValid && busGrant && busReq) begin
                        curCh_ff <= grantIdx;
                        burstCnt_ff <= burstBytes(
                            chCtrl_ff[grantIdx][dma_pkg::BurstLsb +: 2]);
                        state_ff <= dma_pkg::StRead;
                    end
                end
                dma_pkg::StRead: begin
                    state_ff <= illegal ? dma_pkg::StIdle : dma_pkg::StWrite;
                end
                dma_pkg::StWrite: begin
                    dataHold_ff <= busRdata;
                    state_ff <= dma_pkg::StNext;
                end
                dma_pkg::StNext: begin
                    burstCnt_ff <= 4'(burstCnt_ff - 4'h1);
                    if (blockEnd || burstCnt_ff == 4'h1) begin
                        state_ff <= dma_pkg::StIdle;
                    end else begin
                        state_ff <= dma_pkg::StRead;
                    end
                end
                default: state_ff <= dma_pkg::StIdle;
            endcase
        end
    end

    // Bus outputs: read in StRead, write the captured byte in StNext.
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            busAddr <= '0;
            busWdata <= 8'h00;
            busRead <= 1'b0;
            busWrite <= 1'b0;
        end else begin
            busRead <= 1'b0;
            busWrite <= 1'b0;
            if (state_ff == dma_pkg::StIdle && grantValid && busGrant &&
                    busReq && !refused(srcAddr_ff[grantIdx],
                    dstAddr_ff[grantIdx])) begin
                busAddr <= srcAddr_ff[grantIdx];
                busRead <= 1'b1;
            end else if (state_ff == dma_pkg::StWrite) begin
                busAddr <= dstAddr_ff[curCh_ff];
                busWdata <= busRdata;
                busWrite <= 1'b1;
            end else if (state_ff == dma_pkg::StNext && !blockEnd &&
                    burstCnt_ff != 4'h1 && !refused(nxtSrc, nxtDst)) begin
                busAddr <= nxtSrc;
                busRead <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            glbCtrl_ff <= dma_pkg::CtrlReset;
        end else if (regWrite && regAddr == dma_pkg::CtrlOffset) begin
            glbCtrl_ff <= regWdata;
        end
    end

    // Configuration and counters; later assignments win, so a hardware set
    // of done or error beats a software clear in the same cycle.
    for (genvar c = 0; c < NumCh; c++) begin : g_chan
        localparam logic [7:0] Base = 8'(dma_pkg::ChanBase +
            dma_pkg::ChanStride * c);
        logic hit;
        logic active;
        assign hit = regWrite && regAddr[7:3] == Base[7:3];
        assign active = (curCh_ff == 2'(c));
        always_ff @(posedge clk or negedge rstSync_n) begin
            if (!rstSync_n) begin
                chCtrl_ff[c] <= 16'h0000;
                srcStart_ff[c] <= '0;
                dstStart_ff[c] <= '0;
                srcAddr_ff[c] <= '0;
                dstAddr_ff[c] <= '0;
                blkLen_ff[c] <= 16'h0000;
                blkCnt_ff[c] <= 17'h0_0000;
                repeat_ff[c] <= 8'h00;
                repCnt_ff[c] <= 8'h00;
                trigSel_ff[c] <= 8'h00;
                pending_ff[c] <= 1'b0;
                done_ff[c] <= 1'b0;
                err_ff[c] <= 1'b0;
            end else begin
                if (hit) begin
                    case (regAddr[2:0])
                        dma_pkg::ChCtrlIdx: begin
                            chCtrl_ff[c] <= regWdata[15:0];
                            if (regWdata[dma_pkg::SwTrigBit]) begin
                                pending_ff[c] <= 1'b1;
                            end
                        end
                        dma_pkg::ChSrcIdx: begin
                            srcStart_ff[c] <= regWdata[AW-1:0];
                            srcAddr_ff[c] <= regWdata[AW-1:0];
                        end
                        dma_pkg::ChDstIdx: begin
                            dstStart_ff[c] <= regWdata[AW-1:0];
                            dstAddr_ff[c] <= regWdata[AW-1:0];
                        end
                        dma_pkg::ChLenIdx: begin
                            // Zero stands for a full 64 KiB block.
                            blkLen_ff[c] <= regWdata[15:0];
                            blkCnt_ff[c] <= (regWdata[15:0] == 16'h0000) ?
                                17'h1_0000 : {1'b0, regWdata[15:0]};
                        end
                        dma_pkg::ChRepIdx: begin
                            repeat_ff[c] <= regWdata[7:0];
                            repCnt_ff[c] <= regWdata[7:0];
                        end
                        dma_pkg::ChTrigIdx: trigSel_ff[c] <= regWdata[7:0];
                        dma_pkg::ChStatIdx: begin
                            if (regWdata[dma_pkg::DoneBit]) begin
                                done_ff[c] <= 1'b0;
                            end
                            if (regWdata[dma_pkg::ErrBit]) begin
                                err_ff[c] <= 1'b0;
                            end
                        end
                        default: ;
                    endcase
                end
                if (trigRaw[c] && !trigPrev_ff[c]) begin
                    pending_ff[c] <= 1'b1;
                end
                if (active && state_ff == dma_pkg::StRead && illegal) begin
                    err_ff[c] <= 1'b1;
                    pending_ff[c] <= 1'b0;
                    chCtrl_ff[c][dma_pkg::EnableBit] <= 1'b0;
                end
                if (active && state_ff == dma_pkg::StNext) begin
                    srcAddr_ff[c] <= nxtSrc;
                    dstAddr_ff[c] <= nxtDst;
                    blkCnt_ff[c] <= 17'(blkCnt_ff[c] - 17'h1);
                    if (blockEnd) begin
                        pending_ff[c] <= 1'b0;
                        blkCnt_ff[c] <= (blkLen_ff[c] == 16'h0000) ?
                            17'h1_0000 : {1'b0, blkLen_ff[c]};
                        repCnt_ff[c] <= 8'(repCnt_ff[c] - 8'h1);
                        if (repCnt_ff[c] > 8'h1) begin
                            pending_ff[c] <= 1'b1;
                        end
                    end
                    if (chanFinish) begin
                        done_ff[c] <= 1'b1;
                        pending_ff[c] <= 1'b0;
                        chCtrl_ff[c][dma_pkg::EnableBit] <= 1'b0;
                        repCnt_ff[c] <= repeat_ff[c];
                        if (chCtrl_ff[c][dma_pkg::ReloadBit]) begin
                            srcAddr_ff[c] <= srcStart_ff[c];
                            dstAddr_ff[c] <= dstStart_ff[c];
                        end
                    end
                end
                // Partner of an even channel is the next odd one and back.
                if (state_ff == dma_pkg::StNext && chanFinish &&
                        curCh_ff == 2'(c ^ 1) &&
                        chCtrl_ff[c ^ 1][dma_pkg::LinkBit]) begin
                    chCtrl_ff[c][dma_pkg::EnableBit] <= 1'b1;
                    pending_ff[c] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            regRdata <= 32'h0000_0000;
        end else begin
            regRdata <= 32'h0000_0000;
            if (regRead) begin
                if (regAddr == dma_pkg::CtrlOffset) begin
                    regRdata <= glbCtrl_ff;
                end else if (regAddr == dma_pkg::StatusOffset) begin
                    regRdata <= {24'h0, pending_ff, done_ff | err_ff};
                end else if (regAddr == dma_pkg::IdOffset) begin
                    regRdata <= {24'h0, dma_pkg::DeviceIdValue};
                end else if (regAddr >= dma_pkg::ChanBase &&
                        regAddr < 8'h30) begin
                    case (regAddr[2:0])
                        dma_pkg::ChCtrlIdx:
                            regRdata <= {16'h0, chCtrl_ff[rdCh]};
                        dma_pkg::ChSrcIdx:
                            regRdata <= {8'h0, srcAddr_ff[rdCh]};
                        dma_pkg::ChDstIdx:
                            regRdata <= {8'h0, dstAddr_ff[rdCh]};
                        dma_pkg::ChLenIdx:
                            regRdata <= {15'h0, blkCnt_ff[rdCh]};
                        dma_pkg::ChRepIdx:
                            regRdata <= {24'h0, repCnt_ff[rdCh]};
                        dma_pkg::ChTrigIdx:
                            regRdata <= {24'h0, trigSel_ff[rdCh]};
                        dma_pkg::ChStatIdx:
                            regRdata <= {29'h0, pending_ff[rdCh],
                                err_ff[rdCh], done_ff[rdCh]};
                        default: regRdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end
endmodule : direct_memory_mover

// *** sim/dma_bus_model.sv ***
module dma_bus_model #(
    parameter int AW = 24
) (
    input wire logic clk,
    input wire logic slow,
    input wire logic busReq,
    output logic busGrant,
    input wire logic [AW-1:0] busAddr,
    input wire logic busRead,
    input wire logic busWrite,
    output logic [7:0] busRdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic grantDly = 1'b0;
    logic [1:0] holdCnt = 2'h0;
    // Grant is held across a burst, since the mover may drop its request then.
    assign busGrant = (slow ? grantDly : busReq) || (holdCnt != 2'h0);
    initial busRdata = 8'h00;
    always @(posedge clk) begin
        grantDly <= busReq;
        holdCnt <= (busRead || busWrite) ? 2'h3 :
            holdCnt - {1'b0, holdCnt != 0};
        // Data stand one cycle; after that the lines toggle every cycle.
        if (busRead) begin
            busRdata <= busAddr[7:0] ^ 8'hA5;
        end else begin
            busRdata <= ~busRdata;
        end
    end
endmodule : dma_bus_model

// *** sim/direct_memory_mover_sva.sv ***
module direct_memory_mover_sva #(
    parameter int NumCh = 4,
    parameter int AW = 24
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic cpuBusReq,
    input wire logic busReq,
    input wire logic busGrant,
    input wire logic [AW-1:0] busAddr,
    input wire logic busRead,
    input wire logic busWrite
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_write_after_read: assert property (busWrite |-> $past(busRead, 2))
        else $error("bus write without a read two cycles before");
    a_read_granted: assert property (busRead |-> $past(busGrant))
        else $error("bus read without grant");
    a_read_pulse: assert property (busRead |=> !busRead)
        else $error("bus read longer than one cycle");
    a_write_gap: assert property (busWrite |=> !busWrite)
        else $error("bus writes in adjacent cycles");
    a_nvm_no_write: assert property (busWrite |->
        !(busAddr >= dma_pkg::NvmBase && busAddr <= dma_pkg::NvmLimit))
        else $error("write into nonvolatile region");
    a_no_prog_space: assert property ((busRead || busWrite) |->
        busAddr < dma_pkg::ProgBase)
        else $error("access to program space");
    a_quiet_reset: assert property ($rose(rst_n) |->
        (!busRead && !busWrite) [*2])
        else $error("bus active right after reset");
    a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 32'h0)
        else $error("read data outside read slot");
    a_id_value: assert property ($past(regRead) &&
        $past(regAddr) == dma_pkg::IdOffset |->
        regRdata == {24'h0, dma_pkg::DeviceIdValue})
        else $error("identity register wrong");
    c_write: cover property (busWrite);
    c_nvm_read: cover property (busRead && busAddr >= dma_pkg::NvmBase
        && busAddr <= dma_pkg::NvmLimit);
    c_contend: cover property (cpuBusReq && busReq);
endmodule : direct_memory_mover_sva
bind direct_memory_mover direct_memory_mover_sva #(.NumCh(NumCh), .AW(AW))
    u_sva (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regRead(regRead),
    .regRdata(regRdata), .cpuBusReq(cpuBusReq), .busReq(busReq),
    .busGrant(busGrant), .busAddr(busAddr), .busRead(busRead),
    .busWrite(busWrite));

// *** sim/direct_memory_mover_test.sv ***
module direct_memory_mover_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdata;
    logic [15:0] periphReq = 16'h0;
    logic [15:0] eventReq = 16'h0;
    logic cpuBusReq = 1'b0;
    logic slow = 1'b0;
    logic busReq, busGrant, busWrite, busRead, rdSeen = 1'b0;
    logic [23:0] busAddr;
    logic [7:0] busWdata, busRdata;
    logic [31:0] wq[$], rq[$], mq[$], v[4], e, m;
    int badCount = 0;
    int compares = 0;
    int seed = 32'h095C;
    always #2.5 clk = ~clk;
    direct_memory_mover u_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .periphReq(periphReq), .eventReq(eventReq),
        .cpuBusReq(cpuBusReq), .busReq(busReq), .busGrant(busGrant),
        .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite),
        .busRead(busRead), .busRdata(busRdata));
    dma_bus_model u_bus (.clk(clk), .slow(slow), .busReq(busReq),
        .busGrant(busGrant), .busAddr(busAddr), .busRead(busRead),
        .busWrite(busWrite), .busRdata(busRdata));
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
        input logic [31:0] k);
        rq.push_back(x & k);
        mq.push_back(k);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
    endtask : rd
    function automatic logic [7:0] ra(input int c, input logic [2:0] i);
        return dma_pkg::ChanBase + 8'(c) * dma_pkg::ChanStride + 8'(i);
    endfunction : ra
    // Notes the writes expected, then programs the channel; ctrl goes last.
    task automatic setup(input int c, input logic [23:0] s,
        input logic [23:0] d, input int sm, input int dm, input int n,
        input int rep, input logic [31:0] ctl, input logic [31:0] sel);
        int ds = (sm == 1) ? 1 : (sm == 2) ? -1 : 0;
        int dd = (dm == 1) ? 1 : (dm == 2) ? -1 : 0;
        for (int k = 0; k < n * rep && d[23:12] != 12'h001 && !s[23];
                k++) begin
            wq.push_back({d + 24'(dd * k), (s[7:0] + 8'(ds * k)) ^ 8'hA5});
        end
        wr(ra(c, dma_pkg::ChSrcIdx), {8'h0, s});
        wr(ra(c, dma_pkg::ChDstIdx), {8'h0, d});
        wr(ra(c, dma_pkg::ChLenIdx), n);
        wr(ra(c, dma_pkg::ChRepIdx), rep);
        wr(ra(c, dma_pkg::ChTrigIdx), sel);
        wr(ra(c, dma_pkg::ChCtrlIdx), ctl | 32'(sm << 4) | 32'(dm << 6));
    endtask : setup
    task automatic drain();
        for (int i = 0; i < 3000 && wq.size() != 0; i++) begin
            @(posedge clk);
        end
        check("writes left", wq.size(), 0);
        repeat (8) @(posedge clk);
    endtask : drain
    always @(posedge clk) rdSeen <= regRead;
    always @(negedge clk) begin
        if (rdSeen) begin
            e = rq.pop_front();
            m = mq.pop_front();
            check("register read", regRdata & m, e);
        end
        if (rst_n && busWrite === 1'b1) begin
            e = (wq.size() != 0) ? wq.pop_front() : 32'hFFFF_FFFF;
            check("bus write", {busAddr, busWdata}, e);
        end
    end
    initial begin
        repeat (40000) @(posedge clk);
        badCount++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(dma_pkg::IdOffset, {24'h0, dma_pkg::DeviceIdValue}, '1);
        rd(dma_pkg::CtrlOffset, dma_pkg::CtrlReset, '1);
        wr(8'hFF, $random(seed));
        rd(8'hFF, 32'h0, '1);
        wr(dma_pkg::CtrlOffset, 32'h1);
        rd(dma_pkg::CtrlOffset, 32'h1, 32'h1);
        for (int c = 0; c < 4; c++) begin
            v[c] = $random(seed) & 32'h00FF_FFFF;
            wr(ra(c, dma_pkg::ChSrcIdx), v[c]);
        end
        for (int c = 0; c < 4; c++) rd(ra(c, dma_pkg::ChSrcIdx), v[c], '1);
        // Each mode appears at source and destination, with bursts 1, 2, 4.
        for (int c = 0; c < 3; c++) begin
            slow <= c[0];
            v[0] = 32'h2100 | ($random(seed) & 32'hF0);
            setup(c, v[0], 24'h3100 + 24'(c * 16), c, (c + 1) % 3, 5, 1,
                32'h7 | 32'(c << 8), 0);
            drain();
            rd(ra(c, dma_pkg::ChStatIdx), 32'h1, 32'h1);
            rd(ra(c, dma_pkg::ChSrcIdx), v[0], '1);
        end
        setup(3, 24'h2200, 24'h3300, 0, 0, 2, 3, 32'h301, 32'h6);
        @(posedge clk) eventReq[14] <= 1'b1;
        drain();
        eventReq <= 16'h0;
        setup(0, 24'h2500, 24'h3500, 1, 1, 4, 1, 32'h209, 32'h1);
        setup(1, 24'h2400, 24'h3400, 1, 1, 3, 1, 32'h0, 0);
        @(posedge clk) periphReq[1] <= 1'b1;
        drain();
        periphReq <= 16'h0;
        wr(dma_pkg::CtrlOffset, 32'h3);
        cpuBusReq <= 1'b1;
        setup(2, 24'h1800, 24'h3600, 0, 0, 1, 1, 32'h3, 0);
        repeat (20) @(posedge clk);
        check("held off", wq.size(), 1);
        cpuBusReq <= 1'b0;
        drain();
        setup(2, 24'h1800, 24'h1000, 0, 0, 1, 1, 32'h3, 0);
        repeat (40) @(posedge clk);
        rd(ra(2, dma_pkg::ChStatIdx), 32'h2, 32'h2);
        wr(ra(2, dma_pkg::ChStatIdx), 32'h2);
        setup(2, 24'h80_0000, 24'h3700, 0, 0, 1, 1, 32'h3, 0);
        repeat (40) @(posedge clk);
        rd(ra(2, dma_pkg::ChStatIdx), 32'h2, 32'h2);
        repeat (4) @(posedge clk);
        final_report();
    end
endmodule : direct_memory_mover_test
